// ### core/periph_clock_dividers_select.v
`timescale 1ns/1ps
`include "periph_clk_defs.vh"

// Behaviour
// - serial port 0 clock: 8-bit divider, zero stops, 1..255 divides
// - uart clock: own 8-bit divider, zero stops, resets to zero
// - serial port 1 clock: 8-bit divider, resets zero, zero gates off
// - usb clock: divider of selected source, resets to one, zero stops
// - usb source select: 0 pll, 1 main clock, 2 and 3 reserved
// - usb selection applied only on zero-then-one write of update bit
// - usb select reads zero after reset, pll is default source
// - clock output source: 0 rc, 1 crystal, 2 watchdog, 3 main
// - clock output selection applied on zero-to-one toggle of update bit
// - bits above each field are reserved and read zero
// - clock output update bit resets zero, zero no change, one applies only over a stored zero
module periph_clock_dividers_select (
   input  wire        ref_clk,
   input  wire        rst,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata_r,
   output reg         hreadyout_r,
   output reg         hresp_r,
   // usb source ticks, on ref_clk
   input  wire        usbPllTick,
   input  wire        mainClockTick,
   // clock output pin sources, asynchronous levels
   input  wire        internalRcOscIn,
   input  wire        crystalOscIn,
   input  wire        watchdogOscIn,
   input  wire        mainClockIn,
   // peripheral clock enables and the clock output pin level
   output wire        serialPort0Clock,
   output wire        uartClock,
   output wire        serialPort1Clock,
   output wire        usbClock,
   output reg         clockOutputPin_r
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   reg  [7:0]  serialPort0Div_r;
   reg  [7:0]  uartDiv_r;
   reg  [7:0]  serialPort1Div_r;
   reg  [1:0]  usbSel_r;
   reg         usbUpdate_r;
   reg  [7:0]  usbDiv_r;
   reg  [1:0]  clock_output_source_select_r;
   reg         clkOutUpdate_r;

   reg  [7:0]  serialPort0Div_nxt;
   reg  [7:0]  uartDiv_nxt;
   reg  [7:0]  serialPort1Div_nxt;
   reg  [1:0]  usbSel_nxt;
   reg         usbUpdate_nxt;
   reg  [7:0]  usbDiv_nxt;
   reg  [1:0]  clock_output_source_select_nxt;
   reg         clkOutUpdate_nxt;

   reg  [1:0]  usbSelApplied_r;
   reg  [1:0]  clkOutSelApplied_r;

   reg         wrPending_r;
   reg  [31:0] wrAddr_r;

   reg  [31:0] readWord;
   reg         usbSrcTick;
   reg         clkOutSrcLevel;

   wire        addrPhase;
   wire        wrUsbUpdate;
   wire        wrClkOutUpdate;
   wire        ircLevel;
   wire        crystalLevel;
   wire        watchdogLevel;
   wire        mainLevel;

   // ------------------------------------------------------------
   // ahb-lite address phase capture
   // ------------------------------------------------------------

   // a transfer is taken when selected, active and the bus is ready
   assign addrPhase = hsel & hready & htrans[`HTRANS_ACTIVE_BIT];

   // the slave never stalls, so hready is held high from reset onward
   always @(posedge ref_clk) begin
      if (rst) begin
         wrPending_r <= 1'b0;
         wrAddr_r    <= 32'h00000000;
         hreadyout_r <= 1'b1;
         hresp_r     <= `HRESP_OKAY;
      end else begin
         hreadyout_r <= 1'b1;
         hresp_r     <= `HRESP_OKAY;
         if (hready) begin
            wrPending_r <= addrPhase & hwrite;
            wrAddr_r    <= haddr;
         end
      end
   end

   // ------------------------------------------------------------
   // register next values from the write data phase
   // ------------------------------------------------------------

   // only the low field of each word is stored, upper bits dropped
   always @* begin
      serialPort0Div_nxt = serialPort0Div_r;
      uartDiv_nxt        = uartDiv_r;
      serialPort1Div_nxt = serialPort1Div_r;
      usbSel_nxt         = usbSel_r;
      usbUpdate_nxt      = usbUpdate_r;
      usbDiv_nxt         = usbDiv_r;
      clock_output_source_select_nxt      = clock_output_source_select_r;
      clkOutUpdate_nxt   = clkOutUpdate_r;
      if (wrPending_r) begin
         case (wrAddr_r)
            `ADDR_SERIAL_PORT0_CLOCK_DIVIDER: begin
               serialPort0Div_nxt = hwdata[`DIV_MSB:0];
            end
            `ADDR_UART_CLOCK_DIVIDER: begin
               uartDiv_nxt = hwdata[`DIV_MSB:0];
            end
            `ADDR_SERIAL_PORT1_CLOCK_DIVIDER: begin
               serialPort1Div_nxt = hwdata[`DIV_MSB:0];
            end
            `ADDR_USB_CLOCK_SOURCE_SELECT: begin
               usbSel_nxt = hwdata[`SEL_MSB:0];
            end
            `ADDR_USB_CLOCK_SOURCE_UPDATE: begin
               usbUpdate_nxt = hwdata[`UPDATE_BIT];
            end
            `ADDR_USB_CLOCK_DIVIDER: begin
               usbDiv_nxt = hwdata[`DIV_MSB:0];
            end
            `ADDR_CLOCK_OUTPUT_SOURCE_SELECT: begin
               clock_output_source_select_nxt = hwdata[`SEL_MSB:0];
            end
            `ADDR_CLOCK_OUTPUT_SOURCE_UPDATE: begin
               clkOutUpdate_nxt = hwdata[`UPDATE_BIT];
            end
            default: begin
               // unmapped writes are accepted and dropped
               serialPort0Div_nxt = serialPort0Div_r;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // update-bit edge detection
   // ------------------------------------------------------------

   // an update fires only on a written rising edge of the stored bit
   assign wrUsbUpdate    = ~usbUpdate_r & usbUpdate_nxt;
   assign wrClkOutUpdate = ~clkOutUpdate_r & clkOutUpdate_nxt;

   // ------------------------------------------------------------
   // software-visible registers
   // ------------------------------------------------------------

   // reset values put usb on the pll and divide it by one
   always @(posedge ref_clk) begin
      if (rst) begin
         serialPort0Div_r <= `RST_SERIAL_PORT0_DIV;
         uartDiv_r        <= `RST_UART_DIV;
         serialPort1Div_r <= `RST_SERIAL_PORT1_DIV;
         usbSel_r         <= `RST_USB_SEL;
         usbUpdate_r      <= `RST_UPDATE;
         usbDiv_r         <= `RST_USB_DIV;
         clock_output_source_select_r      <= `RST_CLOCK_OUTPUT_PIN_SEL;
         clkOutUpdate_r   <= `RST_UPDATE;
      end else begin
         serialPort0Div_r <= serialPort0Div_nxt;
         uartDiv_r        <= uartDiv_nxt;
         serialPort1Div_r <= serialPort1Div_nxt;
         usbSel_r         <= usbSel_nxt;
         usbUpdate_r      <= usbUpdate_nxt;
         usbDiv_r         <= usbDiv_nxt;
         clock_output_source_select_r      <= clock_output_source_select_nxt;
         clkOutUpdate_r   <= clkOutUpdate_nxt;
      end
   end

   // ------------------------------------------------------------
   // applied mux selections
   // ------------------------------------------------------------

   // rewriting a select alone does not move the mux; software must
   // keep both sources alive across the update, since no glitch guard
   // exists here beyond switching on a register edge
   always @(posedge ref_clk) begin
      if (rst) begin
         usbSelApplied_r    <= `RST_USB_SEL;
         clkOutSelApplied_r <= `RST_CLOCK_OUTPUT_PIN_SEL;
      end else begin
         if (wrUsbUpdate) begin
            usbSelApplied_r <= usbSel_nxt;
         end
         if (wrClkOutUpdate) begin
            clkOutSelApplied_r <= clock_output_source_select_nxt;
         end
      end
   end

   // ------------------------------------------------------------
   // read data, taken in the address phase
   // ------------------------------------------------------------

   // next values are read so a write just before a read is seen
   always @* begin
      readWord = 32'h00000000;
      case (haddr)
         `ADDR_SERIAL_PORT0_CLOCK_DIVIDER: readWord = {24'h0, serialPort0Div_nxt};
         `ADDR_UART_CLOCK_DIVIDER:         readWord = {24'h0, uartDiv_nxt};
         `ADDR_SERIAL_PORT1_CLOCK_DIVIDER: readWord = {24'h0, serialPort1Div_nxt};
         `ADDR_USB_CLOCK_SOURCE_SELECT:    readWord = {30'h0, usbSel_nxt};
         `ADDR_USB_CLOCK_SOURCE_UPDATE:    readWord = {31'h0, usbUpdate_nxt};
         `ADDR_USB_CLOCK_DIVIDER:          readWord = {24'h0, usbDiv_nxt};
         `ADDR_CLOCK_OUTPUT_SOURCE_SELECT: readWord = {30'h0, clock_output_source_select_nxt};
         `ADDR_CLOCK_OUTPUT_SOURCE_UPDATE: readWord = {31'h0, clkOutUpdate_nxt};
         default:                          readWord = 32'h00000000;
      endcase
   end

   // read data stands through the whole data phase
   always @(posedge ref_clk) begin
      if (rst) begin
         hrdata_r <= 32'h00000000;
      end else if (addrPhase & ~hwrite) begin
         hrdata_r <= readWord;
      end
   end

   // ------------------------------------------------------------
   // peripheral dividers on the system clock
   // ------------------------------------------------------------

   // system clock is the divider input, so the source ticks every cycle
   clk_divider #(
      .WIDTH     (`DIV_WIDTH)
   ) serialPort0DivInst (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .srcTick   (1'b1),
      .divValue  (serialPort0Div_r),
      .outTick_r (serialPort0Clock)
   );

   clk_divider #(
      .WIDTH     (`DIV_WIDTH)
   ) uartDivInst (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .srcTick   (1'b1),
      .divValue  (uartDiv_r),
      .outTick_r (uartClock)
   );

   clk_divider #(
      .WIDTH     (`DIV_WIDTH)
   ) serialPort1DivInst (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .srcTick   (1'b1),
      .divValue  (serialPort1Div_r),
      .outTick_r (serialPort1Clock)
   );

   // ------------------------------------------------------------
   // usb clock path
   // ------------------------------------------------------------

   // reserved codes select nothing, so the usb clock simply stops
   always @* begin
      case (usbSelApplied_r)
         `USB_SEL_PLL: begin
            usbSrcTick = usbPllTick;
         end
         `USB_SEL_MAIN: begin
            usbSrcTick = mainClockTick;
         end
         default: begin
            usbSrcTick = 1'b0;
         end
      endcase
   end

   // the 48 mhz target is software's job; any ratio is accepted
   clk_divider #(
      .WIDTH     (`DIV_WIDTH)
   ) usbDivInst (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .srcTick   (usbSrcTick),
      .divValue  (usbDiv_r),
      .outTick_r (usbClock)
   );

   // ------------------------------------------------------------
   // clock output pin path
   // ------------------------------------------------------------

   // oscillator levels arrive from foreign domains
   pin_sync ircSyncInst (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pinIn   (internalRcOscIn),
      .level_r (ircLevel)
   );

   pin_sync crystalSyncInst (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pinIn   (crystalOscIn),
      .level_r (crystalLevel)
   );

   pin_sync watchdogSyncInst (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pinIn   (watchdogOscIn),
      .level_r (watchdogLevel)
   );

   pin_sync mainSyncInst (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pinIn   (mainClockIn),
      .level_r (mainLevel)
   );

   // limitation: sampling caps the visible rate well below ref_clk / 2
   always @* begin
      case (clkOutSelApplied_r)
         `CLOCK_OUTPUT_PIN_SEL_IRC: begin
            clkOutSrcLevel = ircLevel;
         end
         `CLOCK_OUTPUT_PIN_SEL_CRYSTAL: begin
            clkOutSrcLevel = crystalLevel;
         end
         `CLOCK_OUTPUT_PIN_SEL_WDOSC: begin
            clkOutSrcLevel = watchdogLevel;
         end
         `CLOCK_OUTPUT_PIN_SEL_MAIN: begin
            clkOutSrcLevel = mainLevel;
         end
         default: begin
            clkOutSrcLevel = 1'b0;
         end
      endcase
   end

   // pin is registered so a mux change cannot glitch it
   always @(posedge ref_clk) begin
      if (rst) begin
         clockOutputPin_r <= 1'b0;
      end else begin
         clockOutputPin_r <= clkOutSrcLevel;
      end
   end

endmodule // periph_clock_dividers_select

// ### shared/periph_clk_defs.vh
`ifndef PERIPH_CLK_DEFS_VH
`define PERIPH_CLK_DEFS_VH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define ADDR_SERIAL_PORT0_CLOCK_DIVIDER  32'h40048094
`define ADDR_UART_CLOCK_DIVIDER          32'h40048098
`define ADDR_SERIAL_PORT1_CLOCK_DIVIDER  32'h4004809c
`define ADDR_USB_CLOCK_SOURCE_SELECT     32'h400480c0
`define ADDR_USB_CLOCK_SOURCE_UPDATE     32'h400480c4
`define ADDR_USB_CLOCK_DIVIDER           32'h400480c8
`define ADDR_CLOCK_OUTPUT_SOURCE_SELECT  32'h400480e0
`define ADDR_CLOCK_OUTPUT_SOURCE_UPDATE  32'h400480e4

// ------------------------------------------------------------
// field layout
// ------------------------------------------------------------
`define DIV_WIDTH        8
`define DIV_MSB          7
`define SEL_WIDTH        2
`define SEL_MSB          1
`define UPDATE_BIT       0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_SERIAL_PORT0_DIV  8'h00
`define RST_UART_DIV          8'h00
`define RST_SERIAL_PORT1_DIV  8'h00
`define RST_USB_DIV           8'h01
`define RST_USB_SEL           2'h0
`define RST_CLOCK_OUTPUT_PIN_SEL        2'h0
`define RST_UPDATE            1'b0

// ------------------------------------------------------------
// source select codes
// ------------------------------------------------------------
`define USB_SEL_PLL           2'h0
`define USB_SEL_MAIN          2'h1
`define CLOCK_OUTPUT_PIN_SEL_IRC        2'h0
`define CLOCK_OUTPUT_PIN_SEL_CRYSTAL    2'h1
`define CLOCK_OUTPUT_PIN_SEL_WDOSC      2'h2
`define CLOCK_OUTPUT_PIN_SEL_MAIN       2'h3

// ------------------------------------------------------------
// ahb-lite encodings
// ------------------------------------------------------------
`define HTRANS_ACTIVE_BIT     1
`define HRESP_OKAY            1'b0

`endif

// ### core/pin_sync.v
`timescale 1ns/1ps

// ------------------------------------------------------------
// three-stage pin synchroniser with agreement filter
// ------------------------------------------------------------
module pin_sync (
   input  wire ref_clk,
   input  wire rst,
   input  wire pinIn,
   output reg  level_r
);

   reg stage1_r;
   reg stage2_r;
   reg stage3_r;

   // first stage feeds only the second; the level moves once stages 2 and 3 agree
   always @(posedge ref_clk) begin
      if (rst) begin
         stage1_r <= 1'b0;
         stage2_r <= 1'b0;
         stage3_r <= 1'b0;
         level_r  <= 1'b0;
      end else begin
         stage1_r <= pinIn;
         stage2_r <= stage1_r;
         stage3_r <= stage2_r;
         if (stage2_r == stage3_r) begin
            level_r <= stage3_r;
         end
      end
   end

endmodule // pin_sync

// ### core/clk_divider.v
`timescale 1ns/1ps

// ------------------------------------------------------------
// programmable tick divider: zero stops, n divides by n
// ------------------------------------------------------------
module clk_divider #(
   parameter WIDTH = 8
) (
   input  wire             ref_clk,
   input  wire             rst,
   input  wire             srcTick,
   input  wire [WIDTH-1:0] divValue,
   output reg              outTick_r
);

   reg  [WIDTH-1:0] count_r;
   wire [WIDTH-1:0] lastCount;

   assign lastCount = divValue - {{(WIDTH-1){1'b0}}, 1'b1};

   // >= rather than == so a shrinking divisor never strands the counter
   always @(posedge ref_clk) begin
      if (rst) begin
         count_r   <= {WIDTH{1'b0}};
         outTick_r <= 1'b0;
      end else if (divValue == {WIDTH{1'b0}}) begin
         count_r   <= {WIDTH{1'b0}};
         outTick_r <= 1'b0;
      end else if (srcTick) begin
         if (count_r >= lastCount) begin
            count_r   <= {WIDTH{1'b0}};
            outTick_r <= 1'b1;
         end else begin
            count_r   <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
            outTick_r <= 1'b0;
         end
      end else begin
         outTick_r <= 1'b0;
      end
   end

endmodule // clk_divider

// ### verification/periph_clock_checker_assertions.sv
`timescale 1ns/1ps
`include "periph_clk_defs.vh"

// ------------------------------------------------------------
// bus and clock output checks, ports of the top module only
// ------------------------------------------------------------
module periph_clock_checker (
   input wire        ref_clk,
   input wire        rst,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [31:0] hwdata,
   input wire        hready,
   input wire [31:0] hrdata_r,
   input wire        serialPort0Clock,
   input wire        uartClock,
   input wire        usbClock
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // address decode kept apart from the design so a decode slip shows up
   wire mapped = (haddr[31:8] == 24'h400480) &&
                 (haddr[7:0] inside {8'h94, 8'h98, 8'h9c, 8'hc0, 8'hc4, 8'hc8, 8'he0, 8'he4});

   // a taken read, and a taken write followed by its data phase
   sequence s_rd;
      hsel && hready && htrans[1] && !hwrite;
   endsequence
   sequence s_wr(a, v);
      (hsel && hready && htrans[1] && hwrite && haddr == a) ##1 (hwdata[7:0] == v);
   endsequence

   property p_reset_out;
      $fell(rst) |-> !serialPort0Clock && !uartClock && !usbClock && hrdata_r == 32'h0;
   endproperty
   property p_unmapped;
      s_rd ##0 !mapped |=> hrdata_r == 32'h0;
   endproperty
   property p_upper_zero;
      hrdata_r[31:8] == 24'h0;
   endproperty
   property p_sel_bits;
      s_rd ##0 (haddr == `ADDR_USB_CLOCK_SOURCE_SELECT ||
                haddr == `ADDR_CLOCK_OUTPUT_SOURCE_SELECT) |=> hrdata_r[31:2] == 30'h0;
   endproperty
   property p_upd_bits;
      s_rd ##0 (haddr == `ADDR_USB_CLOCK_SOURCE_UPDATE ||
                haddr == `ADDR_CLOCK_OUTPUT_SOURCE_UPDATE) |=> hrdata_r[31:1] == 31'h0;
   endproperty
   // the margins leave room for the divider to pick up its new value
   property p_sp0_off;
      s_wr(`ADDR_SERIAL_PORT0_CLOCK_DIVIDER, 8'h00) |-> ##4 !serialPort0Clock [*3];
   endproperty
   property p_uart_off;
      s_wr(`ADDR_UART_CLOCK_DIVIDER, 8'h00) |-> ##4 !uartClock [*3];
   endproperty
   property p_uart_one;
      s_wr(`ADDR_UART_CLOCK_DIVIDER, 8'h01) |-> ##5 uartClock [*2];
   endproperty
   property p_usb_off;
      s_wr(`ADDR_USB_CLOCK_DIVIDER, 8'h00) |-> ##4 !usbClock [*3];
   endproperty

   a_reset_out: assert property (p_reset_out)
      else $error("clock output or read data high after reset");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read returned data");
   a_upper_zero: assert property (p_upper_zero)
      else $error("reserved upper bits set");
   a_sel_bits: assert property (p_sel_bits)
      else $error("select read has reserved bits set");
   a_upd_bits: assert property (p_upd_bits)
      else $error("update read has reserved bits set");
   a_sp0_off: assert property (p_sp0_off)
      else $error("serial port 0 clock runs with divider zero");
   a_uart_off: assert property (p_uart_off)
      else $error("uart clock runs with divider zero");
   a_uart_one: assert property (p_uart_one)
      else $error("uart clock not continuous with divider one");
   a_usb_off: assert property (p_usb_off)
      else $error("usb clock runs with divider zero");
endmodule // periph_clock_checker

bind periph_clock_dividers_select periph_clock_checker u_periph_clock_checker (
   .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata_r(hrdata_r),
   .serialPort0Clock(serialPort0Clock), .uartClock(uartClock), .usbClock(usbClock)
);

// ### verification/tb_periph_clock_dividers_select.sv
`timescale 1ns/1ps
`include "periph_clk_defs.vh"

module tb_periph_clock_dividers_select;
   logic        ref_clk;
   logic        rst;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic        mainClockTick;
   logic [3:0]  oscSrc;
   wire  [31:0] hrdata_r;
   wire         hreadyout_r;
   wire         hresp_r;
   wire         serialPort0Clock;
   wire         uartClock;
   wire         serialPort1Clock;
   wire         usbClock;
   wire         clockOutputPin_r;
   integer      n_fail;
   integer      n_checks;
   integer      c0, cu, c1, cb, i, k;
   logic [31:0] q;
   logic [31:0] addrTab [8];
   logic [31:0] rstTab  [8];
   logic [31:0] maskTab [8];
   logic [1:0]  usbSeq  [5];
   integer      usbExp  [5];

   // usb pll ticks every cycle, main clock every other cycle, so both differ
   periph_clock_dividers_select u_periph_clock_dividers_select (
      .ref_clk(ref_clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout_r),
      .hrdata_r(hrdata_r), .hreadyout_r(hreadyout_r), .hresp_r(hresp_r),
      .usbPllTick(1'b1), .mainClockTick(mainClockTick), .internalRcOscIn(oscSrc[0]),
      .crystalOscIn(oscSrc[1]), .watchdogOscIn(oscSrc[2]), .mainClockIn(oscSrc[3]),
      .serialPort0Clock(serialPort0Clock), .uartClock(uartClock),
      .serialPort1Clock(serialPort1Clock), .usbClock(usbClock),
      .clockOutputPin_r(clockOutputPin_r)
   );

   // ------------------------------------------------------------
   // clock and main clock tick source
   // ------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      mainClockTick <= ~mainClockTick;
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task close_out;
      begin
         $display("comparisons %0d mismatches %0d", n_checks, n_fail);
         if (n_fail == 0 && n_checks > 0) begin
            $display("All checks passed");
         end else begin
            $display("Checks failed");
         end
         $finish;
      end
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp);
      begin
         n_checks++;
         if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   // bounded wait for hready sampled high at a rising edge
   task wait_rdy;
      integer n;
      begin
         n = 0;
         @(posedge ref_clk);
         while (hreadyout_r !== 1'b1 && n < 100) begin
            n++;
            @(posedge ref_clk);
         end
         if (n >= 100) begin
            n_fail++;
            close_out;
         end
      end
   endtask

   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      begin
         htrans <= 2'h2;
         haddr <= a;
         hwrite <= w;
         wait_rdy();
         htrans <= 2'h0;
         hwdata <= d;
         wait_rdy();
         q = hrdata_r;
         check({31'h0, hresp_r}, 32'h0);
      end
   endtask

   task wr(input logic [31:0] a, input logic [31:0] d);
      begin
         xfer(1'b1, a, d);
      end
   endtask

   task rdchk(input logic [31:0] a, input logic [31:0] exp);
      begin
         xfer(1'b0, a, 32'h0);
         check(q, exp);
      end
   endtask

   task do_reset;
      begin
         rst <= 1'b1;
         repeat (16) @(posedge ref_clk);
         rst <= 1'b0;
      end
   endtask

   // counts pulses after a settling gap, since a new divider needs a few edges
   task count_pulses(input integer n);
      integer j;
      begin
         c0 = 0;
         cu = 0;
         c1 = 0;
         cb = 0;
         repeat (8) @(posedge ref_clk);
         for (j = 0; j < n; j++) begin
            @(posedge ref_clk);
            c0 += (serialPort0Clock === 1'b1);
            cu += (uartClock === 1'b1);
            c1 += (serialPort1Clock === 1'b1);
            cb += (usbClock === 1'b1);
         end
      end
   endtask

   // select, then zero, then one on the update bit
   task usb_apply(input logic [1:0] s);
      begin
         wr(`ADDR_USB_CLOCK_SOURCE_SELECT, {30'h0, s});
         wr(`ADDR_USB_CLOCK_SOURCE_UPDATE, 32'h0);
         wr(`ADDR_USB_CLOCK_SOURCE_UPDATE, 32'h1);
      end
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      mainClockTick = 1'b0;
      oscSrc = 4'h0;
      n_fail = 0;
      n_checks = 0;
      addrTab = '{`ADDR_SERIAL_PORT0_CLOCK_DIVIDER, `ADDR_UART_CLOCK_DIVIDER,
                  `ADDR_SERIAL_PORT1_CLOCK_DIVIDER, `ADDR_USB_CLOCK_SOURCE_SELECT,
                  `ADDR_USB_CLOCK_SOURCE_UPDATE, `ADDR_USB_CLOCK_DIVIDER,
                  `ADDR_CLOCK_OUTPUT_SOURCE_SELECT, `ADDR_CLOCK_OUTPUT_SOURCE_UPDATE};
      rstTab = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
      maskTab = '{32'hff, 32'hff, 32'hff, 32'h3, 32'h1, 32'hff, 32'h3, 32'h1};
      usbSeq = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h0};
      usbExp = '{10, 20, 0, 0, 20};
      do_reset();
      for (i = 0; i < 8; i++) begin
         rdchk(addrTab[i], rstTab[i]);
      end
      rdchk(32'h400480d0, 32'h0);
      for (i = 0; i < 8; i++) begin
         wr(addrTab[i], 32'hffffffff);
         rdchk(addrTab[i], maskTab[i]);
      end
      $display("test registers done");
      // a second reset also returns everything written above to its reset value
      do_reset();
      wr(`ADDR_SERIAL_PORT0_CLOCK_DIVIDER, 32'h3);
      wr(`ADDR_UART_CLOCK_DIVIDER, 32'h1);
      wr(`ADDR_SERIAL_PORT1_CLOCK_DIVIDER, 32'hff);
      count_pulses(510);
      check(c0, 170);
      check(cu, 510);
      check(c1, 2);
      wr(`ADDR_SERIAL_PORT0_CLOCK_DIVIDER, 32'h0);
      wr(`ADDR_UART_CLOCK_DIVIDER, 32'h0);
      wr(`ADDR_SERIAL_PORT1_CLOCK_DIVIDER, 32'h0);
      count_pulses(40);
      check(c0 + cu + c1, 0);
      $display("test dividers done");
      check(cb, 40);
      wr(`ADDR_USB_CLOCK_DIVIDER, 32'h2);
      for (i = 0; i < 5; i++) begin
         usb_apply(usbSeq[i]);
         count_pulses(40);
         check(cb, usbExp[i]);
      end
      wr(`ADDR_USB_CLOCK_SOURCE_SELECT, 32'h1);
      wr(`ADDR_USB_CLOCK_SOURCE_UPDATE, 32'h1);
      count_pulses(40);
      check(cb, 20);
      wr(`ADDR_USB_CLOCK_DIVIDER, 32'h0);
      count_pulses(40);
      check(cb, 0);
      $display("test usb clock done");
      for (i = 0; i < 4; i++) begin
         k = (i + 1) % 4;
         oscSrc <= 4'h1 << k;
         wr(`ADDR_CLOCK_OUTPUT_SOURCE_SELECT, k);
         repeat (8) @(posedge ref_clk);
         check({31'h0, clockOutputPin_r}, 32'h0);
         wr(`ADDR_CLOCK_OUTPUT_SOURCE_UPDATE, 32'h0);
         wr(`ADDR_CLOCK_OUTPUT_SOURCE_UPDATE, 32'h1);
         repeat (8) @(posedge ref_clk);
         check({31'h0, clockOutputPin_r}, 32'h1);
      end
      oscSrc <= 4'h2;
      wr(`ADDR_CLOCK_OUTPUT_SOURCE_SELECT, 32'h1);
      wr(`ADDR_CLOCK_OUTPUT_SOURCE_UPDATE, 32'h1);
      repeat (8) @(posedge ref_clk);
      check({31'h0, clockOutputPin_r}, 32'h0);
      $display("test clock output done");
      close_out();
   end
endmodule // tb_periph_clock_dividers_select
